/* File: rtl/fsftx_pkg.sv */
// Constants, register map and types of the fiber transmit mode controller.
// Assumes one 125 MHz clock and a synchronous active-low reset.
package fsftx_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_TXSIG  = 8'h04;
  localparam logic [7:0] REG_CMD    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RXSIG  = 8'h10;
  localparam logic [7:0] REG_VSECS  = 8'h14;
  // Control register fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_FLOW_LSB  = 4;
  localparam int CTRL_RATE_BIT  = 8;
  localparam int CTRL_ABOF_BIT  = 9;
  localparam int CTRL_DPORT_BIT = 10;
  // Command bits, write one to act
  localparam int CMD_BOF_BIT   = 0;
  localparam int CMD_VINT_BIT  = 1;
  localparam int CMD_VEXT_BIT  = 2;
  localparam int CMD_SELF_BIT  = 3;
  localparam int CMD_CLR_BIT   = 4;
  // Status bits
  localparam int ST_LIGHT = 0;
  localparam int ST_SETUP = 1;
  localparam int ST_OVR   = 2;
  localparam int ST_FERR  = 3;
  localparam int ST_VBUSY = 4;
  localparam int ST_VPASS = 5;
  localparam int ST_VFAIL = 6;
  localparam int ST_RAW   = 7;
  localparam int ST_PAUSE = 8;
  // Reset values
  localparam logic [10:0] CTRL_RST  = 11'h000;
  localparam logic [3:0]  TXSIG_RST = 4'h0;
  localparam logic [7:0]  VSECS_RST = 8'h01;
  // Control word codes on the link (carried with the control flag)
  localparam logic [31:0] CTL_BOF  = 32'h0000_0001;
  localparam logic [31:0] CTL_EOE  = 32'h0000_0002;
  localparam logic [31:0] CTL_GO   = 32'h0000_0003;
  localparam logic [31:0] CTL_STOP = 32'h0000_0004;
  // Line rates in Mbytes/s
  localparam int RATE_LEGACY_MBPS = 106;
  localparam int RATE_FAST_MBPS   = 250;
  // Transmit buffer
  localparam int TXFIFO_BYTES = 1024;
  localparam int WORD_BYTES   = 4;
  localparam int TXFIFO_DEPTH = TXFIFO_BYTES / WORD_BYTES;
  // Timing
  localparam int CLK_HZ         = 125_000_000;
  localparam int VERIFY_UNIT_S  = 1;
  localparam int CYCLES_PER_S   = CLK_HZ * VERIFY_UNIT_S;
  localparam logic [7:0] SELFTEST_S = 8'h05;

  typedef enum logic [2:0] {
    forward_only_mode,
    fiber_disabled_mode,
    raw_sample_mode,
    filtered_send_mode,
    insert_own_blocks_mode
  } fsftx_mode_t;

  typedef enum logic [1:0] {
    pace_disabled_setting,
    pace_send_go_setting,
    pace_echo_setting
  } fsftx_pace_t;
endpackage

/* File: rtl/fsftx_txfifo.sv */
// Flip-flop FIFO for transmit words, show-ahead read port.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/1ns
module fsftx_txfifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 256
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_push,
  input  wire logic [WIDTH-1:0] i_din,
  input  wire logic             i_pop,
  output logic      [WIDTH-1:0] o_dout,
  output logic                  o_full,
  output logic                  o_empty
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // Storage, no reset needed on data
  always_ff @(posedge i_clk)
  begin
    if (i_push)
      mem_q[wr_q] <= i_din;
  end

  // Pointers and fill count
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (i_push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (i_pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(i_push) - (AW+1)'(i_pop);
    end
  end

  assign o_dout  = mem_q[rd_q];
  assign o_full  = (cnt_q == (AW+1)'(DEPTH));
  assign o_empty = (cnt_q == '0);
endmodule

/* File: rtl/fsftx_top.sv */
// Fiber transmit mode controller: chooses what the optical link sends.
// Assumes receive words, ADC samples and data FIFO blocks share i_clk;
// only the light detect pin is asynchronous.
`timescale 1ns/1ns
module fsftx_top #(
  parameter int CYCLES_PER_S = fsftx_pkg::CYCLES_PER_S
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Optical receiver
  input  wire logic        i_sig_detect,
  input  wire logic        i_rx_synced,
  input  wire logic        i_rx_valid,
  input  wire logic [31:0] i_rx_data,
  input  wire logic        i_rx_is_ctl,
  input  wire logic [3:0]  i_rx_bits,
  // Raw ADC samples and measurement trigger
  input  wire logic        i_trigger,
  input  wire logic        i_adc_valid,
  input  wire logic [31:0] i_adc_data,
  // Filtered blocks from the data FIFO
  input  wire logic        i_blk_avail,
  input  wire logic        i_blk_valid,
  input  wire logic [31:0] i_blk_data,
  input  wire logic        i_blk_last,
  output logic             o_blk_ready,
  // Optical transmitter
  input  wire logic        i_tx_ready,
  output logic             o_tx_valid,
  output logic      [31:0] o_tx_data,
  output logic             o_tx_is_ctl,
  output logic      [3:0]  o_tx_bits,
  output logic             o_tx_fc_go,
  output logic             o_tx_en,
  output logic             o_rx_en,
  output logic             o_rate_fast
);
  localparam int DEPTH = fsftx_pkg::TXFIFO_DEPTH;

  fsftx_pkg::fsftx_mode_t mode_req_q;
  fsftx_pkg::fsftx_mode_t mode_q;
  fsftx_pkg::fsftx_pace_t pace_q;
  logic        abof_q, dport_q;
  logic [3:0]  rx_bits_q;
  logic [7:0]  vsecs_q;
  logic [1:0]  light_sync_q;
  logic        setup_err_q, ovr_q, ferr_q;
  logic        raw_armed_q, raw_act_q, paused_q, rx_go_q;
  logic        gen_busy_q, window_q;
  logic        hold_v_q;
  logic [32:0] hold_q;
  logic        pend_bof_q, pend_eoe_q, pend_abof_q;
  logic        v_busy_q, v_ext_q, v_fail_q, v_pass_q, v_seen_q;
  logic [26:0] v_cyc_q;
  logic [7:0]  v_sec_q, v_tgt_q;
  logic [31:0] v_pat_q, v_chk_q;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Received control word with a given code
  function automatic logic rx_code(input logic [31:0] code);
    rx_code = i_rx_valid && i_rx_is_ctl && (i_rx_data == code);
  endfunction

  function automatic logic is_gen(input fsftx_pkg::fsftx_mode_t m);
    is_gen = (m == fsftx_pkg::filtered_send_mode) ||
             (m == fsftx_pkg::insert_own_blocks_mode);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Decode and source selection
  logic wr_ctrl, wr_txsig, wr_cmd, wr_vsecs;
  logic cmd_clr, cmd_vint, cmd_vext, cmd_self;
  logic light, off, pace_on, rx_stop, rx_go, rx_fc;
  logic rx_fwd, adc_in, pend_any, word_edge;
  logic f_push, f_pop, f_full, f_empty;
  logic [32:0] f_din, f_dout;
  logic blk_take, hold_push, gen_start, raw_err;

  assign wr_ctrl  = i_wr && (i_addr == fsftx_pkg::REG_CTRL);
  assign wr_txsig = i_wr && (i_addr == fsftx_pkg::REG_TXSIG);
  assign wr_cmd   = i_wr && (i_addr == fsftx_pkg::REG_CMD);
  assign wr_vsecs = i_wr && (i_addr == fsftx_pkg::REG_VSECS);
  assign cmd_clr  = wr_cmd && i_wdata[fsftx_pkg::CMD_CLR_BIT];
  assign cmd_vint = wr_cmd && i_wdata[fsftx_pkg::CMD_VINT_BIT];
  assign cmd_vext = wr_cmd && i_wdata[fsftx_pkg::CMD_VEXT_BIT];
  assign cmd_self = wr_cmd && i_wdata[fsftx_pkg::CMD_SELF_BIT];

  assign light   = light_sync_q[1];
  assign off     = (mode_q == fsftx_pkg::fiber_disabled_mode);
  // Pacing ignored entirely when disabled
  assign pace_on = (pace_q != fsftx_pkg::pace_disabled_setting) && !off;
  assign rx_stop = rx_code(fsftx_pkg::CTL_STOP);
  assign rx_go   = rx_code(fsftx_pkg::CTL_GO);
  assign rx_fc   = rx_stop || rx_go;

  // Forward received words, pacing words are consumed here
  assign rx_fwd = !v_busy_q && i_rx_valid && !rx_fc &&
                  ((mode_q == fsftx_pkg::forward_only_mode) ||
                   (mode_q == fsftx_pkg::insert_own_blocks_mode));
  // Samples enter unfiltered and unstalled
  assign adc_in = !v_busy_q && raw_act_q && i_adc_valid;
  assign pend_any = pend_bof_q || pend_eoe_q || pend_abof_q;

  // Push priority: verify pattern, received, raw, events, own block
  always_comb
  begin
    f_din     = '0;
    hold_push = 1'b0;
    if (v_busy_q)
      f_din = {1'b0, v_pat_q};
    else if (rx_fwd)
      f_din = {i_rx_is_ctl, i_rx_data};
    else if (adc_in)
      f_din = {1'b0, i_adc_data};
    else if (pend_bof_q)
      f_din = {1'b1, fsftx_pkg::CTL_BOF};
    else if (pend_eoe_q)
      f_din = {1'b1, fsftx_pkg::CTL_EOE};
    else if (pend_abof_q)
      f_din = {1'b1, fsftx_pkg::CTL_BOF};
    else if (hold_v_q)
    begin
      f_din     = hold_q;
      hold_push = !f_full;
    end
  end

  assign f_push = !f_full &&
                  (v_busy_q || rx_fwd || adc_in || pend_any || hold_v_q);
  // Sample or received word with nowhere to go is lost
  assign raw_err = f_full && (rx_fwd || adc_in);

  // Drain stalls while paused; raw mode then overflows
  assign f_pop = !f_empty && (!o_tx_valid || i_tx_ready) &&
                 (v_busy_q || !(pace_on && paused_q));
  assign word_edge = !o_tx_valid || i_tx_ready;

  fsftx_txfifo #(
    .WIDTH (33),
    .DEPTH (DEPTH)
  ) u_txfifo (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_push   (f_push),
    .i_din    (f_din),
    .i_pop    (f_pop),
    .o_dout   (f_dout),
    .o_full   (f_full),
    .o_empty  (f_empty)
  );

  assign blk_take  = o_blk_ready && i_blk_valid;
  assign gen_start = !gen_busy_q && !v_busy_q && i_blk_avail &&
                     ((mode_q == fsftx_pkg::filtered_send_mode) ||
                      (mode_q == fsftx_pkg::insert_own_blocks_mode &&
                       window_q));

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      mode_req_q  <= fsftx_pkg::forward_only_mode;
      pace_q      <= fsftx_pkg::pace_disabled_setting;
      o_rate_fast <= fsftx_pkg::CTRL_RST[fsftx_pkg::CTRL_RATE_BIT];
      abof_q      <= fsftx_pkg::CTRL_RST[fsftx_pkg::CTRL_ABOF_BIT];
      dport_q     <= fsftx_pkg::CTRL_RST[fsftx_pkg::CTRL_DPORT_BIT];
      o_tx_bits   <= fsftx_pkg::TXSIG_RST;
      vsecs_q     <= fsftx_pkg::VSECS_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        mode_req_q  <= fsftx_pkg::fsftx_mode_t'(
                         i_wdata[fsftx_pkg::CTRL_MODE_LSB +: 3]);
        pace_q      <= fsftx_pkg::fsftx_pace_t'(
                         i_wdata[fsftx_pkg::CTRL_FLOW_LSB +: 2]);
        // One bit sets both directions' line rate
        o_rate_fast <= i_wdata[fsftx_pkg::CTRL_RATE_BIT];
        abof_q      <= i_wdata[fsftx_pkg::CTRL_ABOF_BIT];
        dport_q     <= i_wdata[fsftx_pkg::CTRL_DPORT_BIT];
      end
      if (wr_txsig)
        o_tx_bits <= i_wdata[3:0];
      if (wr_vsecs)
        vsecs_q <= i_wdata[7:0];
    end
  end

  // Mode applied only between words on the link
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      mode_q <= fsftx_pkg::forward_only_mode;
    else if (word_edge)
      mode_q <= mode_req_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive side status
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      light_sync_q <= 2'h0;
      rx_bits_q    <= 4'h0;
    end
    else
    begin
      light_sync_q <= {light_sync_q[0], i_sig_detect};
      // Captured in every mode, never interpreted
      rx_bits_q    <= i_rx_bits;
    end
  end

  // Pacing state from received GO and STOP
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      paused_q <= 1'b0;
      rx_go_q  <= 1'b1;
    end
    else
    begin
      if (rx_go)
        rx_go_q <= 1'b1;
      else if (rx_stop)
        rx_go_q <= 1'b0;
      if (!pace_on)
        paused_q <= 1'b0;
      else if (rx_stop)
        paused_q <= 1'b1;
      else if (rx_go)
        paused_q <= 1'b0;
    end
  end

  // Sent pacing value: fixed GO or echo of received
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_tx_fc_go <= 1'b1;
    else
      o_tx_fc_go <= (pace_q == fsftx_pkg::pace_echo_setting) ?
                    rx_go_q : 1'b1;
  end

  // Laser follows light alone; disabled mode shuts both paths
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_tx_en <= 1'b0;
      o_rx_en <= 1'b0;
    end
    else
    begin
      o_tx_en <= light && !off;
      o_rx_en <= !off;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error flags; a new event wins over the clear command
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      setup_err_q <= 1'b0;
      ovr_q       <= 1'b0;
      ferr_q      <= 1'b0;
    end
    else
    begin
      // Fiber cannot carry both streams at once
      if (dport_q && (mode_req_q == fsftx_pkg::raw_sample_mode ||
                      mode_req_q == fsftx_pkg::forward_only_mode))
        setup_err_q <= 1'b1;
      else if (cmd_clr)
        setup_err_q <= 1'b0;
      if (raw_err)
        ovr_q <= 1'b1;
      else if (cmd_clr)
        ovr_q <= 1'b0;
      // Light without lock, or overrun, counts as a fiber error
      if ((light && !i_rx_synced && !off) || raw_err)
        ferr_q <= 1'b1;
      else if (cmd_clr)
        ferr_q <= 1'b0;
    end
  end

  // Raw streaming: armed on selection, live from first trigger
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      raw_armed_q <= 1'b0;
      raw_act_q   <= 1'b0;
    end
    else if (mode_q != fsftx_pkg::raw_sample_mode || ferr_q || raw_err)
    begin
      raw_armed_q <= 1'b0;
      raw_act_q   <= 1'b0;
    end
    else
    begin
      // Runs past measurement end; filtered path is not touched
      if (!raw_act_q && !raw_armed_q)
        raw_armed_q <= 1'b1;
      if (raw_armed_q && i_trigger)
        raw_act_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Own block transfer; one holding word decouples ready from the FIFO
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      gen_busy_q  <= 1'b0;
      hold_v_q    <= 1'b0;
      hold_q      <= '0;
      o_blk_ready <= 1'b0;
      window_q    <= 1'b0;
    end
    else
    begin
      // Block starts once it is whole in the data FIFO
      if (gen_start)
        gen_busy_q <= 1'b1;
      else if (blk_take && i_blk_last)
        gen_busy_q <= 1'b0;
      if (blk_take)
        hold_q <= {1'b0, i_blk_data};
      hold_v_q    <= blk_take || (hold_v_q && !hold_push);
      o_blk_ready <= (gen_busy_q || gen_start) &&
                     !(blk_take && i_blk_last) &&
                     !(blk_take || (hold_v_q && !hold_push));
      // Insert slot opens after a received end-of-epoch
      if (gen_start || rx_code(fsftx_pkg::CTL_BOF))
        window_q <= 1'b0;
      else if (mode_q == fsftx_pkg::insert_own_blocks_mode &&
               rx_code(fsftx_pkg::CTL_EOE))
        window_q <= 1'b1;
    end
  end

  // Pending events; manual request wins over the clear of its flag
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      pend_bof_q  <= 1'b0;
      pend_eoe_q  <= 1'b0;
      pend_abof_q <= 1'b0;
    end
    else
    begin
      if (wr_cmd && i_wdata[fsftx_pkg::CMD_BOF_BIT] && !off)
        pend_bof_q <= 1'b1;
      else if (f_push && !v_busy_q && !rx_fwd && !adc_in)
        pend_bof_q <= 1'b0;
      if (hold_push && !gen_busy_q)
        pend_eoe_q <= 1'b1;
      else if (f_push && !v_busy_q && !rx_fwd && !adc_in && !pend_bof_q)
        pend_eoe_q <= 1'b0;
      // Auto begin-of-frame queued behind each end-of-epoch in filtered send mode
      if (hold_push && !gen_busy_q && abof_q &&
          mode_q == fsftx_pkg::filtered_send_mode)
        pend_abof_q <= 1'b1;
      else if (f_push && !v_busy_q && !rx_fwd && !adc_in &&
               !pend_bof_q && !pend_eoe_q)
        pend_abof_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output word register toward the serializer
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_tx_valid  <= 1'b0;
      o_tx_data   <= '0;
      o_tx_is_ctl <= 1'b0;
    end
    else if (f_pop)
    begin
      o_tx_valid  <= 1'b1;
      o_tx_data   <= f_dout[31:0];
      o_tx_is_ctl <= f_dout[32];
    end
    else if (i_tx_ready)
      o_tx_valid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Loop checks: counting pattern, checked at drain or on receive
  logic v_start, v_sec_tick, v_word, v_bad;
  assign v_start    = !v_busy_q && (cmd_vint || cmd_vext || cmd_self);
  assign v_sec_tick = v_busy_q && (v_cyc_q == 27'(CYCLES_PER_S - 1));
  // Internal path checks FIFO output, optical path the receiver
  assign v_word = v_ext_q ? (i_rx_valid && !i_rx_is_ctl) : f_pop;
  assign v_bad  = v_word &&
                  ((v_ext_q ? i_rx_data : f_dout[31:0]) != v_chk_q);

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      v_busy_q <= 1'b0;
      v_ext_q  <= 1'b0;
      v_fail_q <= 1'b0;
      v_pass_q <= 1'b0;
      v_seen_q <= 1'b0;
      v_cyc_q  <= '0;
      v_sec_q  <= '0;
      v_tgt_q  <= '0;
      v_pat_q  <= '0;
      v_chk_q  <= '0;
    end
    else if (v_start)
    begin
      v_busy_q <= 1'b1;
      v_ext_q  <= cmd_vext && !cmd_self;
      // Self-test always takes the internal path for five seconds
      v_tgt_q  <= cmd_self ? fsftx_pkg::SELFTEST_S : vsecs_q;
      v_fail_q <= 1'b0;
      v_pass_q <= 1'b0;
      v_seen_q <= 1'b0;
      v_cyc_q  <= '0;
      v_sec_q  <= '0;
      v_pat_q  <= '0;
      v_chk_q  <= '0;
    end
    else if (v_busy_q)
    begin
      v_cyc_q <= v_sec_tick ? '0 : v_cyc_q + 1'b1;
      if (f_push)
        v_pat_q <= v_pat_q + 1'b1;
      if (v_word)
      begin
        v_chk_q  <= v_chk_q + 1'b1;
        v_seen_q <= 1'b1;
      end
      if (v_bad)
        v_fail_q <= 1'b1;
      if (v_sec_tick)
      begin
        v_sec_q <= v_sec_q + 1'b1;
        if (v_sec_q + 8'h01 >= v_tgt_q)
        begin
          v_busy_q <= 1'b0;
          v_pass_q <= !v_fail_q && !v_bad && v_seen_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port, data in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_rdata <= '0;
    else if (i_rd)
    begin
      o_rdata <= '0;
      case (i_addr)
        fsftx_pkg::REG_CTRL:
          o_rdata[10:0] <= {dport_q, abof_q, o_rate_fast, 2'b00,
                            pace_q, 1'b0, mode_req_q};
        fsftx_pkg::REG_TXSIG:
          o_rdata[3:0] <= o_tx_bits;
        fsftx_pkg::REG_STATUS:
          o_rdata[8:0] <= {paused_q, raw_act_q, v_fail_q, v_pass_q,
                           v_busy_q, ferr_q, ovr_q, setup_err_q,
                           light};
        fsftx_pkg::REG_RXSIG:
          o_rdata[3:0] <= rx_bits_q;
        fsftx_pkg::REG_VSECS:
          o_rdata[7:0] <= vsecs_q;
        default:
          o_rdata <= '0;
      endcase
    end
  end
endmodule

/* File: tb/fsftx_sva.sv */
// Port checker for the fiber transmit mode controller.
// Assumes it is bound into fsftx_top; one clock domain.
`timescale 1ns/1ns
module fsftx_sva (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_sig_detect,
  input wire logic [3:0]  i_rx_bits,
  input wire logic        i_tx_ready,
  input wire logic        o_tx_valid,
  input wire logic [31:0] o_tx_data,
  input wire logic [3:0]  o_tx_bits,
  input wire logic        o_tx_fc_go,
  input wire logic        o_tx_en,
  input wire logic        o_rx_en,
  input wire logic        o_rate_fast
);
  ////////////////////////////////////////////////////////////////////////////
  // Pacing field as last written, to know when GO is owed
  logic [1:0] pace_q;
  always_ff @(posedge i_clk)
    if (!i_resetn)
      pace_q <= 2'h0;
    else if (i_wr && i_addr == fsftx_pkg::REG_CTRL)
      pace_q <= i_wdata[5:4];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////////////////////////////////////////////////
  property p_light; (i_sig_detect && o_rx_en) [*5] |-> o_tx_en; endproperty
  a_light: assert property (p_light) else $error("laser off");
  property p_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("word moved");
  property p_rate;
    i_wr && i_addr == fsftx_pkg::REG_CTRL |=> o_rate_fast == $past(i_wdata[8]);
  endproperty
  a_rate: assert property (p_rate) else $error("rate wrong");
  property p_txbits; i_wr && i_addr == fsftx_pkg::REG_TXSIG
    |=> o_tx_bits == $past(i_wdata[3:0]); endproperty
  a_txbits: assert property (p_txbits) else $error("tx bits");
  property p_txrd; i_rd && i_addr == fsftx_pkg::REG_TXSIG
    |=> o_rdata[3:0] == $past(o_tx_bits); endproperty
  a_txrd: assert property (p_txrd) else $error("tx bits read");
  property p_sendgo; pace_q == 2'h1 && $past(pace_q) == 2'h1 |-> o_tx_fc_go;
  endproperty
  a_sendgo: assert property (p_sendgo) else $error("GO not sent");
  property p_rxsig; $stable(i_rx_bits) [*4] ##0 (i_rd && i_addr ==
    fsftx_pkg::REG_RXSIG) |=> o_rdata[3:0] == $past(i_rx_bits); endproperty
  a_rxsig: assert property (p_rxsig) else $error("rx bits read");
  property p_off; !o_rx_en [*2] |-> !o_tx_en; endproperty
  a_off: assert property (p_off) else $error("laser in off");
endmodule
bind fsftx_top fsftx_sva u_sva (.*);

/* File: tb/fsftx_far.sv */
// Far-end optical link model: takes transmitted words.
// Assumes the bench picks prompt or stalling acceptance.
`timescale 1ns/1ns
module fsftx_far (
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  input  wire logic        i_valid,
  input  wire logic [32:0] i_word,
  output logic             o_ready,
  output int               o_cnt,
  output logic      [32:0] o_last
);
  // Stalls every other cycle when slow, like a busy serializer
  initial o_ready = 1'h1;
  always @(posedge i_clk)
  begin
    if (i_valid && o_ready)
    begin
      o_cnt <= o_cnt + 1;
      o_last <= i_word;
    end
    o_ready <= i_slow ? !o_ready : 1'h1;
  end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the fiber transmit mode controller.
// Assumes the far-end model and the bound checker are compiled first.
`timescale 1ns/1ns
module tb;
  logic        i_clk, i_resetn, i_wr, i_rd, i_sig_detect, i_rx_synced;
  logic        i_rx_valid, i_rx_is_ctl, i_trigger, i_adc_valid, i_tx_ready;
  logic        i_blk_avail, i_blk_valid, i_blk_last, o_blk_ready, slow;
  logic        o_tx_valid, o_tx_is_ctl, o_tx_fc_go, o_tx_en, o_rx_en;
  logic        o_rate_fast;
  logic [7:0]  i_addr;
  logic [3:0]  i_rx_bits, o_tx_bits;
  logic [31:0] i_wdata, o_rdata, i_rx_data, i_adc_data, i_blk_data;
  logic [31:0] o_tx_data, rv;
  logic [32:0] last;
  int          cnt, n, fail_count, samples_checked, cyc;
  // Far end model paces the link; block path driven by t_gen
  fsftx_top #(.CYCLES_PER_S(50)) dut (.*);
  fsftx_far u_far (.i_clk(i_clk), .i_slow(slow), .i_valid(o_tx_valid),
    .i_word({o_tx_is_ctl, o_tx_data}), .o_ready(i_tx_ready), .o_cnt(cnt),
    .o_last(last));
  initial
  begin
    i_clk = 1'h0;
    forever #4 i_clk = ~i_clk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] got, logic [32:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus cycle; read data caught in the cycle after the strobe
  task automatic bus(input logic w, logic [7:0] a, logic [31:0] d);
    {i_wr, i_rd, i_addr, i_wdata} <= {w, !w, a, d};
    @(posedge i_clk);
    {i_wr, i_rd} <= 2'h0;
    #1 rv = o_rdata;
    @(posedge i_clk);
  endtask
  // One received word (a low) or raw sample (a high), then settle
  task automatic snd(input logic a, logic c, logic [31:0] d);
    {i_adc_valid, i_rx_valid, i_rx_is_ctl} <= {a, !a, c};
    {i_rx_data, i_adc_data} <= {d, d};
    @(posedge i_clk);
    {i_adc_valid, i_rx_valid} <= 2'h0;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic wt(input int k);
    for (int j = 0; j < 40 && cnt < k; j++)
      @(posedge i_clk);
  endtask
  task automatic t_fwd();
    bus(1'h0, fsftx_pkg::REG_CTRL, 32'h0);
    chk(rv, {21'h0, fsftx_pkg::CTRL_RST});
    chk({o_tx_fc_go, o_rate_fast, o_tx_bits}, 6'h20);
    chk(o_tx_en, 1'h1);
    bus(1'h0, fsftx_pkg::REG_STATUS, 32'h0);
    chk(rv[fsftx_pkg::ST_LIGHT], 1'h1);
    snd(1'h0, 1'h0, 32'hC0DE_0001);
    wt(1);
    chk(last, {1'h0, 32'hC0DE_0001});
    bus(1'h1, fsftx_pkg::REG_CMD, 32'h1);
    wt(2);
    chk(last, {1'h1, fsftx_pkg::CTL_BOF});
    bus(1'h1, fsftx_pkg::REG_TXSIG, 32'hA);
    chk(o_tx_bits, 4'hA);
    bus(1'h0, fsftx_pkg::REG_RXSIG, 32'h0);
    chk(rv, 32'h5);
    bus(1'h1, fsftx_pkg::REG_CTRL, 32'h100);
    chk(o_rate_fast, 1'h1);
    $display("forward test done");
  endtask
  // Pause and resume under the echo setting, then STOP under send-GO and disabled, far end stalling
  task automatic t_pace();
    bus(1'h1, fsftx_pkg::REG_CTRL, 32'h20);
    snd(1'h0, 1'h1, fsftx_pkg::CTL_STOP);
    chk(o_tx_fc_go, 1'h0);
    n = cnt;
    snd(1'h0, 1'h0, 32'h0BAD);
    chk(cnt, n);
    snd(1'h0, 1'h1, fsftx_pkg::CTL_GO);
    wt(n + 1);
    chk(last, {1'h0, 32'h0BAD});
    chk(o_tx_fc_go, 1'h1);
    bus(1'h1, fsftx_pkg::REG_CTRL, 32'h10);
    snd(1'h0, 1'h1, fsftx_pkg::CTL_STOP);
    chk(o_tx_fc_go, 1'h1);
    bus(1'h1, fsftx_pkg::REG_CTRL, 32'h0);
    snd(1'h0, 1'h1, fsftx_pkg::CTL_STOP);
    snd(1'h0, 1'h0, 32'h0ACE);
    wt(n + 2);
    chk(last, {1'h0, 32'h0ACE});
    $display("pacing test done");
  endtask
  task automatic t_raw();
    bus(1'h1, fsftx_pkg::REG_CTRL, 32'h2);
    n = cnt;
    snd(1'h1, 1'h0, 32'h111);
    chk(cnt, n);
    i_trigger <= 1'h1;
    @(posedge i_clk);
    i_trigger <= 1'h0;
    snd(1'h1, 1'h0, 32'h222);
    wt(n + 1);
    chk(last, {1'h0, 32'h222});
    snd(1'h1, 1'h0, 32'h333);
    wt(n + 2);
    chk(last, {1'h0, 32'h333});
    bus(1'h1, fsftx_pkg::REG_CTRL, 32'h402);
    bus(1'h0, fsftx_pkg::REG_STATUS, 32'h0);
    chk(rv[fsftx_pkg::ST_SETUP], 1'h1);
    bus(1'h1, fsftx_pkg::REG_CTRL, 32'h1);
    i_rx_bits <= 4'h9;
    @(posedge i_clk);
    bus(1'h0, fsftx_pkg::REG_RXSIG, 32'h0);
    chk(rv, 32'h9);
    chk({o_rx_en, o_tx_en}, 2'h0);
    $display("raw test done");
  endtask
  // Block then loop check
  task automatic t_gen();
    bus(1'h1, fsftx_pkg::REG_CTRL, 32'h203);
    n = cnt;
    {i_blk_avail, i_blk_valid, i_blk_last} <= 3'h7;
    i_blk_data <= 32'hB10C;
    @(posedge i_clk);
    while (!o_blk_ready) @(posedge i_clk);
    {i_blk_avail, i_blk_valid, i_blk_last} <= 3'h0;
    wt(n + 1);
    chk(last, {1'h0, 32'hB10C});
    chk(o_blk_ready, 1'h0);
    wt(n + 2);
    chk(last, {1'h1, fsftx_pkg::CTL_EOE});
    wt(n + 3);
    chk(last, {1'h1, fsftx_pkg::CTL_BOF});
    bus(1'h1, fsftx_pkg::REG_CMD, 32'h2);
    repeat (60) @(posedge i_clk);
    bus(1'h0, fsftx_pkg::REG_STATUS, 32'h0);
    chk(rv[fsftx_pkg::ST_VPASS], 1'h1);
    $display("block test done");
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    {i_resetn, i_wr, i_rd, i_addr, i_wdata, i_trigger, slow} = '0;
    {i_sig_detect, i_rx_synced, i_rx_bits} = {1'h1, 1'h1, 4'h5};
    {i_rx_valid, i_rx_is_ctl, i_rx_data, i_adc_valid, i_adc_data} = '0;
    {i_blk_avail, i_blk_valid, i_blk_data, i_blk_last} = '0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'h1;
    repeat (5) @(posedge i_clk);
    t_fwd();
    slow <= 1'h1;
    t_pace();
    t_raw();
    t_gen();
    end_of_test();
  end
endmodule
